// ===== rtl/spi_fram_pkg.sv
// Shared constants and types for the SPI nonvolatile memory command block
`default_nettype none

package spi_fram_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Array geometry
	localparam int              ADDR_W              = 17;
	localparam int              MEM_DEPTH           = 131072;
	localparam logic [1:0]      ADDR_BYTES_LAST     = 2'h2;    // Index of last of three address bytes

	////////////////////////////////////////////////////////////////////////////
	// Opcodes
	localparam logic [7:0]      LATCH_SET_CMD       = 8'h06;
	localparam logic [7:0]      LATCH_CLEAR_CMD     = 8'h04;
	localparam logic [7:0]      STATUS_READ_CMD     = 8'h05;
	localparam logic [7:0]      STATUS_WRITE_CMD    = 8'h01;
	localparam logic [7:0]      READ_CMD            = 8'h03;
	localparam logic [7:0]      FAST_READ_CMD       = 8'h0B;
	localparam logic [7:0]      WRITE_CMD           = 8'h02;
	localparam logic [7:0]      SLEEP_CMD           = 8'hB9;
	localparam logic [7:0]      IDENT_READ_CMD      = 8'h9F;
	localparam logic [7:0]      SERIAL_NUMBER_READ_CMD = 8'hC3;

	////////////////////////////////////////////////////////////////////////////
	// Protection/status register layout and values
	localparam int              GUARD_PIN_ENABLE_BIT = 7;
	localparam int              FIXED_ONE_BIT        = 6;
	localparam int              BLOCK_GUARD_HI_BIT   = 3;
	localparam int              BLOCK_GUARD_LO_BIT   = 2;
	localparam int              WRITE_LATCH_FLAG_BIT = 1;
	localparam logic            LATCH_RESET          = 1'b0;
	localparam logic            GUARD_PIN_ENABLE_FACTORY = 1'b0;
	localparam logic [1:0]      BLOCK_GUARD_FACTORY  = 2'h0;
	localparam logic [7:0]      STATUS_RESET         = 8'h40;

	////////////////////////////////////////////////////////////////////////////
	// Block-protect ranges
	localparam logic [ADDR_W-1:0] PROT_QUARTER_BASE  = 17'h18000;
	localparam logic [ADDR_W-1:0] PROT_HALF_BASE     = 17'h10000;

	////////////////////////////////////////////////////////////////////////////
	// Command sequencer states
	typedef enum logic [2:0] {
		ST_OPCODE   = 3'b000,
		ST_ADDR     = 3'b001,
		ST_DUMMY    = 3'b010,
		ST_WDATA    = 3'b011,
		ST_RDATA    = 3'b100,
		ST_STATUS_W = 3'b101,
		ST_STATUS_R = 3'b110,
		ST_IGNORE   = 3'b111
	} cmd_state_e;

endpackage : spi_fram_pkg

`default_nettype wire

// ===== rtl/spi_byte_if.sv
// Byte-level link between the serial shifter and the command core
`timescale 1ns/10ps
`default_nettype none

interface spi_byte_if;
	logic       frame_rst;     // Asynchronous frame reset, high while deselected
	logic [2:0] bit_idx;       // Bit position within current byte
	logic [7:0] rx_byte_next;  // Byte including the bit on SI now
	logic       byte_end;      // This rising edge completes a byte
	logic [7:0] tx_byte;       // Byte to shift out next
	logic       tx_en;         // Output phase active

	modport engine (
		input  frame_rst,
		input  tx_byte,
		input  tx_en,
		output bit_idx,
		output rx_byte_next,
		output byte_end
	);

	modport core (
		output frame_rst,
		output tx_byte,
		output tx_en,
		input  bit_idx,
		input  rx_byte_next,
		input  byte_end
	);
endinterface : spi_byte_if

`default_nettype wire

// ===== rtl/spi_bit_engine.sv
// Serial shifter: samples SI on rising SCK, drives SO on falling SCK
`timescale 1ns/10ps
`default_nettype none

module spi_bit_engine
	import spi_fram_pkg::*;
(
	input  wire logic       sck_i,
	input  wire logic       si_i,
	spi_byte_if.engine      bus,
	output var  logic       so_o,
	output var  logic       so_oe_o
);

	logic [2:0] bit_idx;
	logic [6:0] rx_sh;
	logic [2:0] next_bit_idx;
	logic [6:0] next_rx_sh;
	logic [6:0] tx_sh;
	logic       next_so;
	logic       next_so_oe;
	logic [6:0] next_tx_sh;

	////////////////////////////////////////////////////////////////////////////
	// Receive side
	// Byte assembly, MSB first
	always_comb
	begin
		next_bit_idx = bit_idx + 3'h1;
		next_rx_sh   = {rx_sh[5:0], si_i};
	end

	always_ff @(posedge sck_i or posedge bus.frame_rst)
	begin
		if (bus.frame_rst)
		begin
			bit_idx <= 3'h0;
			rx_sh   <= 7'h00;
		end
		else
		begin
			bit_idx <= next_bit_idx;
			rx_sh   <= next_rx_sh;
		end
	end

	assign bus.bit_idx      = bit_idx;
	assign bus.rx_byte_next = {rx_sh, si_i};
	assign bus.byte_end     = (bit_idx == 3'h7);

	////////////////////////////////////////////////////////////////////////////
	// Transmit side
	// Load a fresh byte at each byte boundary, else shift
	always_comb
	begin
		next_so_oe = bus.tx_en;
		if (bus.tx_en && bit_idx == 3'h0)
		begin
			next_so    = bus.tx_byte[7];
			next_tx_sh = bus.tx_byte[6:0];
		end
		else
		begin
			next_so    = tx_sh[6];
			next_tx_sh = {tx_sh[5:0], 1'b0};
		end
	end

	always_ff @(negedge sck_i or posedge bus.frame_rst)
	begin
		if (bus.frame_rst)
		begin
			so_o    <= 1'b0;
			so_oe_o <= 1'b0;
			tx_sh   <= 7'h00;
		end
		else
		begin
			so_o    <= next_so;
			so_oe_o <= next_so_oe;
			tx_sh   <= next_tx_sh;
		end
	end

endmodule : spi_bit_engine

`default_nettype wire

// ===== rtl/spi_fram_command_protect.sv
// SPI memory command decoder with write latch, block protection and array
`timescale 1ns/10ps
`default_nettype none

module spi_fram_command_protect
	import spi_fram_pkg::*;
(
	input  wire logic       ref_clk_i,
	input  wire logic       rst_i,
	input  wire logic       cs_n_i,
	input  wire logic       sck_i,
	input  wire logic       si_i,
	input  wire logic       write_guard_n_i,
	output var  logic       so_o,
	output var  logic       so_oe_o,
	output var  logic [7:0] protection_status_o,
	output var  logic       frame_active_o,
	output var  logic       spi_mode_o
);

	////////////////////////////////////////////////////////////////////////////
	// Helper functions

	// fixed bits, never busy
	// Compose the status byte from its live fields
	function automatic logic [7:0] status_word(
		input logic       pin_en,
		input logic [1:0] guard,
		input logic       latch_flag
	);
		logic [7:0] w;
		w = 8'h00;
		w[GUARD_PIN_ENABLE_BIT] = pin_en;
		w[FIXED_ONE_BIT]        = 1'b1;
		w[BLOCK_GUARD_HI_BIT]   = guard[1];
		w[BLOCK_GUARD_LO_BIT]   = guard[0];
		w[WRITE_LATCH_FLAG_BIT] = latch_flag;
		return w;
	endfunction : status_word

	function automatic logic addr_guarded(
		input logic [ADDR_W-1:0] a,
		input logic [1:0]        guard
	);
		logic hit;
		unique case (guard)
			2'h0: hit = 1'b0;
			2'h1: hit = (a >= PROT_QUARTER_BASE);
			2'h2: hit = (a >= PROT_HALF_BASE);
			2'h3: hit = 1'b1;
		endcase
		return hit;
	endfunction : addr_guarded

	////////////////////////////////////////////////////////////////////////////
	// Declarations

	spi_byte_if lnk ();

	cmd_state_e        state;
	cmd_state_e        next_state;
	logic [ADDR_W-1:0] addr;
	logic [ADDR_W-1:0] next_addr;
	logic [1:0]        addr_cnt;
	logic [1:0]        next_addr_cnt;
	logic              is_write;
	logic              next_is_write;
	logic              is_fast;
	logic              next_is_fast;
	logic              write_stop;
	logic              next_write_stop;

	logic              latch;
	logic              next_latch;
	logic              drop_pending;
	logic              next_drop_pending;
	logic              guard_pin_enable = GUARD_PIN_ENABLE_FACTORY;
	logic              next_guard_pin_enable;
	logic [1:0]        block_guard = BLOCK_GUARD_FACTORY;
	logic [1:0]        next_block_guard;
	logic              wp_meta;
	logic              wp_sync;
	logic [7:0]        status_snap;
	logic [7:0]        next_status_snap;
	logic              snap_tgl;
	logic              next_snap_tgl;

	logic [7:0]        mem [MEM_DEPTH];
	logic              mem_we;
	logic              guarded_now;
	logic              first_edge;
	logic              mode_cap;

	logic              tgl_meta;
	logic              tgl_sync;
	logic              tgl_prev;
	logic              cs_meta;
	logic              mode_meta;
	logic [7:0]        next_protection_status;

	////////////////////////////////////////////////////////////////////////////
	// Serial shifter

	// frame logic held in reset while deselected
	assign lnk.frame_rst = rst_i | cs_n_i;

	// status byte or array byte goes to the shifter
	assign lnk.tx_byte = (state == ST_RDATA) ? mem[addr]
	                                         : status_word(guard_pin_enable, block_guard, latch);
	// output enabled only in read phases
	assign lnk.tx_en   = (state == ST_RDATA) || (state == ST_STATUS_R);

	spi_bit_engine u_engine (
		.sck_i   (sck_i),
		.si_i    (si_i),
		.bus     (lnk.engine),
		.so_o    (so_o),
		.so_oe_o (so_oe_o)
	);

	////////////////////////////////////////////////////////////////////////////
	// Command sequencer (link clock, reset by deselect)

	assign guarded_now = addr_guarded(addr, block_guard);

	// Next state of the per-frame sequencer
	always_comb
	begin
		next_state      = state;
		next_addr       = addr;
		next_addr_cnt   = addr_cnt;
		next_is_write   = is_write;
		next_is_fast    = is_fast;
		next_write_stop = write_stop;
		if (lnk.byte_end)
		begin
			unique case (state)
				ST_OPCODE:
				begin
					// first byte of a frame is the opcode
					unique case (lnk.rx_byte_next)
						STATUS_READ_CMD:  next_state = ST_STATUS_R;
						STATUS_WRITE_CMD: next_state = latch ? ST_STATUS_W : ST_IGNORE;
						READ_CMD:         next_state = ST_ADDR;
						// fast read flagged for dummy byte
						FAST_READ_CMD:
						begin
							next_state   = ST_ADDR;
							next_is_fast = 1'b1;
						end
						// write only with the latch set
						WRITE_CMD:
						begin
							next_state    = latch ? ST_ADDR : ST_IGNORE;
							next_is_write = 1'b1;
						end
						LATCH_SET_CMD, LATCH_CLEAR_CMD, SLEEP_CMD,
						IDENT_READ_CMD, SERIAL_NUMBER_READ_CMD:
							next_state = ST_IGNORE;
						default:          next_state = ST_IGNORE;
					endcase
				end
				ST_ADDR:
				begin
					// upper address bits fall off the top
					next_addr     = {addr[ADDR_W-9:0], lnk.rx_byte_next};
					next_addr_cnt = addr_cnt + 2'h1;
					if (addr_cnt == ADDR_BYTES_LAST)
					begin
						if (is_write)
							next_state = ST_WDATA;
						else if (is_fast)
							next_state = ST_DUMMY;
						else
							next_state = ST_RDATA;
					end
				end
				ST_DUMMY:    next_state = ST_RDATA;
				ST_WDATA:
				begin
					if (write_stop || guarded_now)
						next_write_stop = 1'b1;
					else
						next_addr = addr + 17'h00001;
				end
				// read bursts advance one byte at a time
				ST_RDATA:    next_addr = addr + 17'h00001;
				ST_STATUS_W: next_state = ST_IGNORE;
				ST_STATUS_R: next_state = ST_STATUS_R;
				ST_IGNORE:   next_state = ST_IGNORE;
			endcase
		end
	end

	always_ff @(posedge sck_i or posedge lnk.frame_rst)
	begin
		if (lnk.frame_rst)
		begin
			state      <= ST_OPCODE;
			addr       <= '0;
			addr_cnt   <= 2'h0;
			is_write   <= 1'b0;
			is_fast    <= 1'b0;
			write_stop <= 1'b0;
		end
		else
		begin
			state      <= next_state;
			addr       <= next_addr;
			addr_cnt   <= next_addr_cnt;
			is_write   <= next_is_write;
			is_fast    <= next_is_fast;
			write_stop <= next_write_stop;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Memory array

	// array write gated by latch path and block protection only
	assign mem_we = lnk.byte_end && (state == ST_WDATA) && !write_stop && !guarded_now;

	// byte committed on its eighth rising edge
	always_ff @(posedge sck_i)
	begin
		if (mem_we)
			mem[addr] <= lnk.rx_byte_next;
	end

	////////////////////////////////////////////////////////////////////////////
	// Latch and protection register (link clock, survives deselect)

	assign first_edge = (state == ST_OPCODE) && (lnk.bit_idx == 3'h0);

	// Next values of latch, protection fields and snapshot
	always_comb
	begin
		next_latch            = latch;
		next_drop_pending     = drop_pending;
		next_guard_pin_enable = guard_pin_enable;
		next_block_guard      = block_guard;
		next_status_snap      = status_snap;
		next_snap_tgl         = snap_tgl;
		// deferred clear lands before the next opcode
		if (first_edge && drop_pending)
		begin
			next_latch        = 1'b0;
			next_drop_pending = 1'b0;
		end
		if (lnk.byte_end && state == ST_OPCODE)
		begin
			// only this opcode sets the latch
			if (lnk.rx_byte_next == LATCH_SET_CMD)
				next_latch = 1'b1;
			// clear armed for end of frame
			if (lnk.rx_byte_next == LATCH_CLEAR_CMD || lnk.rx_byte_next == STATUS_WRITE_CMD ||
			    lnk.rx_byte_next == WRITE_CMD)
				next_drop_pending = 1'b1;
		end
		// guard pin blocks status writes when enabled
		if (lnk.byte_end && state == ST_STATUS_W && !(guard_pin_enable && !wp_sync))
		begin
			// only guard enable and block-protect bits change
			next_guard_pin_enable = lnk.rx_byte_next[GUARD_PIN_ENABLE_BIT];
			next_block_guard      = {lnk.rx_byte_next[BLOCK_GUARD_HI_BIT],
			                         lnk.rx_byte_next[BLOCK_GUARD_LO_BIT]};
		end
		// Publish settled status at each byte for the system side
		if (lnk.byte_end)
		begin
			next_status_snap = status_word(next_guard_pin_enable, next_block_guard,
			                               next_latch & ~next_drop_pending);
			next_snap_tgl    = ~snap_tgl;
		end
	end

	always_ff @(posedge sck_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			latch        <= LATCH_RESET;
			drop_pending <= 1'b0;
			wp_meta      <= 1'b1;
			wp_sync      <= 1'b1;
			status_snap  <= STATUS_RESET;
			snap_tgl     <= 1'b0;
		end
		else
		begin
			latch        <= next_latch;
			drop_pending <= next_drop_pending;
			wp_meta      <= write_guard_n_i;
			wp_sync      <= wp_meta;
			status_snap  <= next_status_snap;
			snap_tgl     <= next_snap_tgl;
		end
	end

	always_ff @(posedge sck_i)
	begin
		guard_pin_enable <= next_guard_pin_enable;
		block_guard      <= next_block_guard;
	end

	always_ff @(negedge cs_n_i or posedge rst_i)
	begin
		if (rst_i)
			mode_cap <= 1'b0;
		else
			mode_cap <= sck_i;
	end

	////////////////////////////////////////////////////////////////////////////
	// System clock side: status mirror, activity and mode

	// Take the snapshot once its toggle has crossed
	always_comb
	begin
		next_protection_status = protection_status_o;
		if (tgl_sync != tgl_prev)
			next_protection_status = status_snap;
	end

	// Two-stage synchronisers and mirror register
	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			tgl_meta            <= 1'b0;
			tgl_sync            <= 1'b0;
			tgl_prev            <= 1'b0;
			cs_meta             <= 1'b0;
			frame_active_o      <= 1'b0;
			mode_meta           <= 1'b0;
			spi_mode_o          <= 1'b0;
			protection_status_o <= STATUS_RESET;
		end
		else
		begin
			tgl_meta            <= snap_tgl;
			tgl_sync            <= tgl_meta;
			tgl_prev            <= tgl_sync;
			cs_meta             <= ~cs_n_i;
			frame_active_o      <= cs_meta;
			mode_meta           <= mode_cap;
			spi_mode_o          <= mode_meta;
			protection_status_o <= next_protection_status;
		end
	end

endmodule : spi_fram_command_protect

`default_nettype wire

// ===== verification/spi_fram_command_protect_assertions.sv
// Concurrent checks on the pins of the memory command block
`timescale 1ns/10ps
`default_nettype none

module spi_fram_command_protect_assertions (
	input  wire logic       ref_clk_i,
	input  wire logic       rst_i,
	input  wire logic       cs_n_i,
	input  wire logic       sck_i,
	input  wire logic       write_guard_n_i,
	input  wire logic       so_oe_o,
	input  wire logic [7:0] protection_status_o,
	input  wire logic       frame_active_o,
	input  wire logic       spi_mode_o
);
	logic guard_pin_enable_q;

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (rst_i);

	////////////////////////////////////////////////////////////////////////////
	// Guard enable as it stood one clock earlier
	always_ff @(posedge ref_clk_i)
		guard_pin_enable_q <= protection_status_o[7];

	////////////////////////////////////////////////////////////////////////////
	// Pin level relations
	a_oe_deselect: assert property (cs_n_i |-> !so_oe_o)
		else $error("serial output enabled while deselected");
	a_frame_start: assert property ($fell(cs_n_i) |-> ##[1:3] frame_active_o)
		else $error("frame flag missed the select");
	a_frame_end: assert property ($rose(cs_n_i) |-> ##[1:3] !frame_active_o)
		else $error("frame flag outlived the deselect");
	a_fixed_bits: assert property (protection_status_o[6] && protection_status_o[5:4] == 2'h0)
		else $error("fixed status bits wrong");
	a_never_busy: assert property (!protection_status_o[0])
		else $error("status busy bit set");
	a_mode_pick: assert property ($fell(cs_n_i) |-> ##4 spi_mode_o == $past(sck_i, 4))
		else $error("clock mode not taken from idle clock level");
	a_status_quiet: assert property ($changed(protection_status_o) |-> frame_active_o || $past(frame_active_o, 2))
		else $error("status changed outside a frame");
	a_guard_block: assert property (guard_pin_enable_q && !write_guard_n_i && !$past(write_guard_n_i, 8)
		|-> $stable(protection_status_o[7:2]))
		else $error("status written while guard pin low");
	a_reset_state: assert property ($fell(rst_i) |-> !protection_status_o[1] && !so_oe_o && !spi_mode_o)
		else $error("wrong state after reset");
endmodule : spi_fram_command_protect_assertions

`default_nettype wire

// ===== verification/spi_master_model.sv
// Behavioural SPI bus master for the memory's serial pins
`timescale 1ns/10ps
`default_nettype none

module spi_master_model (
	output var  logic cs_n_o,
	output var  logic sck_o,
	output var  logic si_o,
	input  wire logic so_i,
	input  wire logic so_oe_i
);
	logic idle_sck;

	// Bus idle at time zero, clock standing still
	initial
	begin
		cs_n_o = 1'b1;
		sck_o = 1'b0;
		si_o = 1'b0;
		idle_sck = 1'b0;
	end

	// Park clock at the mode's idle level, then select
	task automatic open_frame(input logic mode3);
		idle_sck = mode3;
		sck_o = mode3;
		#100;
		cs_n_o = 1'b0;
		#100;
	endtask : open_frame

	// Return clock to idle, deselect and scramble the released data line
	task automatic close_frame();
		sck_o = idle_sck;
		#200;
		cs_n_o = 1'b1;
		si_o = ~si_o;
		#300;
	endtask : close_frame

	// change on low phase, sample at rise
	task automatic bit1(input logic b, output logic r, output logic oe);
		sck_o = 1'b0;
		si_o = b;
		#24;
		sck_o = 1'b1;
		r = so_i;
		oe = so_oe_i;
		#24;
	endtask : bit1

	// One byte, most significant bit first; oe tells if any bit was driven
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic oe);
		logic r;
		logic o;
		oe = 1'b0;
		for (int i = 7; i >= 0; i--)
		begin
			bit1(tx[i], r, o);
			rx[i] = r;
			oe |= o;
		end
	endtask : xfer
endmodule : spi_master_model

`default_nettype wire

// ===== verification/test_spi_fram_command_protect.sv
// Self-checking bench for the SPI memory command block
`timescale 1ns/10ps
`default_nettype none

module test_spi_fram_command_protect
	import spi_fram_pkg::*;
	;
	logic       ref_clk_i;
	logic       rst_i;
	logic       cs_n;
	logic       sck;
	logic       si;
	logic       write_guard_n;
	logic       so;
	logic       so_oe;
	logic [7:0] status;
	logic       frame_active;
	logic       spi_mode;
	int         err_count;
	int         samples_checked;
	int         cycles;
	logic       use_mode3;

	// 40 MHz reference clock
	initial
	begin
		ref_clk_i = 1'b0;
		forever #12.5 ref_clk_i = ~ref_clk_i;
	end

	spi_fram_command_protect DUT (
		.ref_clk_i           (ref_clk_i),
		.rst_i               (rst_i),
		.cs_n_i              (cs_n),
		.sck_i               (sck),
		.si_i                (si),
		.write_guard_n_i     (write_guard_n),
		.so_o                (so),
		.so_oe_o             (so_oe),
		.protection_status_o (status),
		.frame_active_o      (frame_active),
		.spi_mode_o          (spi_mode)
	);

	spi_master_model master (
		.cs_n_o  (cs_n),
		.sck_o   (sck),
		.si_o    (si),
		.so_i    (so),
		.so_oe_i (so_oe)
	);

	////////////////////////////////////////////////////////////////////////////
	// Comparison and closing
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			err_count++;
			$display("Error at %0t ns: saw %h, expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic complete_run();
		$display("Checks %0d, mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : complete_run

	////////////////////////////////////////////////////////////////////////////
	// Frame helpers
	task automatic solo(input logic [7:0] op);
		logic [7:0] r;
		logic       e;
		master.open_frame(use_mode3);
		master.xfer(op, r, e);
		master.close_frame();
	endtask : solo

	task automatic send24(input logic [23:0] v, output logic [23:0] r, output logic e);
		logic [7:0] b;
		logic       o;
		e = 1'b0;
		for (int i = 0; i < 3; i++)
		begin
			master.xfer(v[23-8*i -: 8], b, o);
			r[23-8*i -: 8] = b;
			e |= o;
		end
	endtask : send24

	task automatic stat_rd(input logic m3, input logic [7:0] exp);
		logic [7:0] r;
		logic       e;
		master.open_frame(m3);
		check({7'h0, spi_mode}, {7'h0, m3});
		master.xfer(STATUS_READ_CMD, r, e);
		master.xfer(8'h00, r, e);
		check(r, exp);
		master.close_frame();
		check(status, exp);
	endtask : stat_rd

	task automatic stat_wr(input logic [7:0] d);
		logic [7:0] r;
		logic       e;
		solo(LATCH_SET_CMD);
		master.open_frame(use_mode3);
		master.xfer(STATUS_WRITE_CMD, r, e);
		master.xfer(d, r, e);
		master.close_frame();
	endtask : stat_wr

	task automatic mem_wr(input logic arm, input logic [23:0] a, input logic [23:0] d);
		logic [23:0] r;
		logic        e;
		if (arm)
			solo(LATCH_SET_CMD);
		master.open_frame(use_mode3);
		master.xfer(WRITE_CMD, r[7:0], e);
		send24(a, r, e);
		send24(d, r, e);
		master.close_frame();
	endtask : mem_wr

	task automatic mem_rd(input logic [7:0] op, input logic [23:0] a, input logic [23:0] exp);
		logic [23:0] r;
		logic        e;
		master.open_frame(use_mode3);
		master.xfer(op, r[7:0], e);
		send24(a, r, e);
		check({7'h0, e}, 8'h00);
		if (op == FAST_READ_CMD)
			master.xfer(8'h00, r[7:0], e);
		check({7'h0, e}, 8'h00);
		send24(24'hFFFFFF, r, e);
		check({7'h0, e}, 8'h01);
		for (int i = 0; i < 3; i++)
			check(r[23-8*i -: 8], exp[23-8*i -: 8]);
		master.close_frame();
		check({7'h0, so_oe}, 8'h00);
	endtask : mem_rd

	////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_latch();
		logic r;
		logic e;
		stat_rd(1'b0, 8'h40);
		solo(LATCH_SET_CMD);
		stat_rd(1'b0, 8'h42);
		solo(LATCH_CLEAR_CMD);
		stat_rd(1'b0, 8'h40);
		// half opcodes in two frames do not join
		master.open_frame(1'b0);
		for (int i = 0; i < 4; i++)
			master.bit1(1'b0, r, e);
		master.close_frame();
		master.open_frame(1'b0);
		for (int i = 0; i < 4; i++)
			master.bit1(i[0] ^ i[1], r, e);
		master.close_frame();
		stat_rd(1'b1, 8'h40);
	endtask : t_latch

	task automatic t_status();
		@(negedge ref_clk_i);
		write_guard_n = 1'b0;
		// pin ignored while guard enable clear
		stat_wr(8'hFF);
		stat_rd(1'b1, 8'hCC);
		// guard enable set and pin low blocks the write
		stat_wr(8'h00);
		stat_rd(1'b0, 8'hCC);
		@(negedge ref_clk_i);
		write_guard_n = 1'b1;
		// pin high lets the write through
		stat_wr(8'h00);
		stat_rd(1'b0, 8'h40);
	endtask : t_status

	task automatic t_burst();
		@(negedge ref_clk_i);
		write_guard_n = 1'b0;
		// bursts run in clock mode 3
		use_mode3 = 1'b1;
		// guard pin low, top address bits ignored, wrap
		mem_wr(1'b1, 24'hFFFFFF, 24'hA53C5A);
		stat_rd(1'b0, 8'h40);
		mem_wr(1'b0, 24'h000000, 24'h112233);
		mem_rd(READ_CMD, 24'h01FFFF, 24'hA53C5A);
		mem_rd(FAST_READ_CMD, 24'hFFFFFF, 24'hA53C5A);
		@(negedge ref_clk_i);
		write_guard_n = 1'b1;
		use_mode3 = 1'b0;
	endtask : t_burst

	task automatic t_protect();
		mem_wr(1'b1, 24'h017FFF, 24'h00E1E2);
		stat_wr(8'h04);
		stat_rd(1'b0, 8'h44);
		// upper quarter stops the burst, first byte kept
		mem_wr(1'b1, 24'h017FFF, 24'h778899);
		mem_rd(READ_CMD, 24'h017FFF, 24'h77E1E2);
		stat_wr(8'h08);
		mem_wr(1'b1, 24'h017FFF, 24'h555555);
		mem_rd(READ_CMD, 24'h017FFF, 24'h77E1E2);
		stat_wr(8'h0C);
		mem_wr(1'b1, 24'h000000, 24'h445566);
		mem_rd(READ_CMD, 24'h01FFFF, 24'hA53C5A);
	endtask : t_protect

	task automatic t_ignore();
		logic [7:0]  ops [4];
		logic [23:0] r;
		logic        e;
		ops = '{8'hFF, IDENT_READ_CMD, SERIAL_NUMBER_READ_CMD, SLEEP_CMD};
		// output stays released for these opcodes
		foreach (ops[k])
		begin
			master.open_frame(use_mode3);
			send24({ops[k], 16'h0000}, r, e);
			master.close_frame();
			check({7'h0, e}, 8'h00);
		end
	endtask : t_ignore

	// Mid-run reset: latch drops, block-protect bits stay
	task automatic t_reset();
		solo(LATCH_SET_CMD);
		@(negedge ref_clk_i);
		rst_i = 1'b1;
		repeat (3) @(negedge ref_clk_i);
		rst_i = 1'b0;
		repeat (4) @(negedge ref_clk_i);
		check(status, STATUS_RESET);
		stat_rd(1'b0, 8'h4C);
	endtask : t_reset

	////////////////////////////////////////////////////////////////////////////
	// Hang guard
	always @(posedge ref_clk_i)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			err_count++;
			complete_run();
		end
	end

	// Main sequence
	initial
	begin
		rst_i = 1'b1;
		write_guard_n = 1'b1;
		err_count = 0;
		samples_checked = 0;
		cycles = 0;
		use_mode3 = 1'b0;
		repeat (12) @(posedge ref_clk_i);
		@(negedge ref_clk_i);
		rst_i = 1'b0;
		repeat (20) @(negedge ref_clk_i);
		t_latch();
		t_status();
		t_burst();
		t_protect();
		t_ignore();
		t_reset();
		complete_run();
	end
endmodule : test_spi_fram_command_protect

bind spi_fram_command_protect spi_fram_command_protect_assertions chk (
	.ref_clk_i           (ref_clk_i),
	.rst_i               (rst_i),
	.cs_n_i              (cs_n_i),
	.sck_i               (sck_i),
	.write_guard_n_i     (write_guard_n_i),
	.so_oe_o             (so_oe_o),
	.protection_status_o (protection_status_o),
	.frame_active_o      (frame_active_o),
	.spi_mode_o          (spi_mode_o)
);

`default_nettype wire
